// [rtl/srs_pkg.sv]
/*
  package for the self refresh sequencer of an sdram device:
  command encodings, timing constants, pin bundle and state codes.
  assumes a 25 MHz core clock (40 ns period).
*/
package srs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 40;
  localparam int T_RAS_MIN_NS     = 50;
  localparam int T_EXIT_SLOW_NS   = 80;
  localparam int T_EXIT_FAST_NS   = 75;
  localparam int EXIT_MIN_CYC     = 2;
  localparam int RAS_MIN_CYC      = (T_RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXIT_NS_CYC      = (T_EXIT_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXIT_CYC         = (EXIT_NS_CYC > EXIT_MIN_CYC) ? EXIT_NS_CYC : EXIT_MIN_CYC;

  // ----------------------------------------------------------------
  // refresh and internal self timer
  // ----------------------------------------------------------------
  localparam int ROW_W            = 13;
  localparam int SELF_TICK_CYC    = 195;
  localparam int SELF_BUSY_CYC    = 2;

  // ----------------------------------------------------------------
  // command encodings {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_NOP     = 4'h7;

  typedef struct packed {
    logic       cke;
    logic [3:0] cmd;
  } srs_pins_t;

  typedef enum logic [3:0] {
    ST_NORMAL = 4'h1,
    ST_SELF   = 4'h2,
    ST_EXIT   = 4'h4,
    ST_ERROR  = 4'h8
  } srs_state_t;

endpackage

// [rtl/srs_self_refresh.sv]
/*
  self refresh entry/exit logic of the sdram device with a shared
  row refresh counter and an internal refresh timer.
  assumes pins sampled on core_clk_i; internal timer modelled on the
  same clock since the device keeps its own oscillator running.
*/
`timescale 1ns/10ps
module srs_self_refresh #(
  parameter int EXIT_CYCLES = srs_pkg::EXIT_CYC,
  parameter int TICK_CYCLES = srs_pkg::SELF_TICK_CYC
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire srs_pkg::srs_pins_t        pins_i,
  output logic                           self_refresh_o,
  output logic                           cmd_ready_o,
  output logic                           refresh_busy_o,
  output logic                           protocol_err_o,
  output logic [srs_pkg::ROW_W-1:0]      refresh_row_o
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  localparam int EXIT_MAX = 255;   // exit counter is 8 bits
  localparam int TICK_MAX = 65535; // internal timer is 16 bits
  localparam int TICK_MIN = 4;     // leaves room for one busy period
  localparam int BUSY_MAX = 3;     // busy counter is 2 bits

  // refused at elaboration, not at run time
  if (EXIT_CYCLES < srs_pkg::EXIT_MIN_CYC || EXIT_CYCLES > EXIT_MAX) begin : g_exit_chk
    $error("EXIT_CYCLES out of range");
  end
  if (TICK_CYCLES < TICK_MIN || TICK_CYCLES > TICK_MAX) begin : g_tick_chk
    $error("TICK_CYCLES out of range");
  end
  if (srs_pkg::SELF_BUSY_CYC < 1 || srs_pkg::SELF_BUSY_CYC > BUSY_MAX) begin : g_busy_chk
    $error("SELF_BUSY_CYC does not fit the busy counter");
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic is_refresh(input logic [3:0] cmd);
    is_refresh = (cmd == srs_pkg::CMD_REFRESH);
  endfunction

  // nop or deselect: the only commands allowed in the exit delay
  function automatic logic is_quiet(input logic [3:0] cmd);
    is_quiet = (cmd == srs_pkg::CMD_NOP) || cmd[3];
  endfunction

  // ----------------------------------------------------------------
  // state and decoded events
  // ----------------------------------------------------------------
  srs_pkg::srs_state_t        state;
  logic [7:0]                 exit_cnt;
  logic [15:0]                tick_cnt;
  logic [1:0]                 busy_cnt;
  logic                       self_entry;
  logic                       auto_ref;
  logic                       exit_req;
  logic                       exit_bad;
  logic                       exit_done;
  logic                       self_ref_tick;
  logic                       refresh_start;

  // self entry only from normal; auto only while commands accepted
  assign self_entry    = (state == srs_pkg::ST_NORMAL) && !pins_i.cke && is_refresh(pins_i.cmd);
  assign auto_ref      = (state == srs_pkg::ST_NORMAL) && pins_i.cke && is_refresh(pins_i.cmd);
  // cke is the only input still watched in self refresh
  assign exit_req      = (state == srs_pkg::ST_SELF) && pins_i.cke;
  assign exit_bad      = (state == srs_pkg::ST_EXIT) && !is_quiet(pins_i.cmd);
  assign exit_done     = (state == srs_pkg::ST_EXIT) && (exit_cnt == 8'h00);
  assign self_ref_tick = (state == srs_pkg::ST_SELF) && (tick_cnt == 16'(TICK_CYCLES - 1));
  assign refresh_start = self_ref_tick || auto_ref;

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= srs_pkg::ST_NORMAL;
    end else begin
      case (state)
        srs_pkg::ST_NORMAL: begin
          if (self_entry) begin
            state <= srs_pkg::ST_SELF;
          end
        end
        srs_pkg::ST_SELF: begin
          // all other inputs ignored here
          if (exit_req) begin
            state <= srs_pkg::ST_EXIT;
          end
        end
        srs_pkg::ST_EXIT: begin
          if (exit_bad) begin
            state <= srs_pkg::ST_ERROR;
          end else if (exit_done) begin
            state <= srs_pkg::ST_NORMAL;
          end
        end
        srs_pkg::ST_ERROR: begin
          if (is_quiet(pins_i.cmd)) begin
            state <= srs_pkg::ST_NORMAL;
          end
        end
        default: state <= srs_pkg::ST_NORMAL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // exit delay counter
  // ----------------------------------------------------------------
  // reloaded on every exit so a cut exit leaves nothing behind
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      exit_cnt <= 8'h00;
    end else if (exit_req) begin
      exit_cnt <= 8'(EXIT_CYCLES - 1);
    end else if (state == srs_pkg::ST_EXIT && exit_cnt != 8'h00) begin
      exit_cnt <= exit_cnt - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // internal refresh timer
  // ----------------------------------------------------------------
  // restarts on every entry so the first tick is a full interval away
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt <= 16'h0000;
    end else if (state != srs_pkg::ST_SELF) begin
      tick_cnt <= 16'h0000;
    end else if (self_ref_tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // refresh busy
  // ----------------------------------------------------------------
  // in-progress refresh may run into the exit window
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt <= 2'h0;
    end else if (refresh_start) begin
      busy_cnt <= 2'(srs_pkg::SELF_BUSY_CYC);
    end else if (busy_cnt != 2'h0) begin
      busy_cnt <= busy_cnt - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // shared row counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      refresh_row_o <= '0;
    end else if (refresh_start) begin
      refresh_row_o <= refresh_row_o + {{(srs_pkg::ROW_W - 1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      self_refresh_o <= 1'b0;
    end else begin
      self_refresh_o <= (state == srs_pkg::ST_SELF);
    end
  end

  // low from entry until the exit delay has run out
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_ready_o <= 1'b1;
    end else begin
      cmd_ready_o <= (state == srs_pkg::ST_NORMAL);
    end
  end

  // covers the cycle in which a refresh starts
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      refresh_busy_o <= 1'b0;
    end else begin
      refresh_busy_o <= (busy_cnt != 2'h0) || refresh_start;
    end
  end

  // stands until a nop or deselect is seen
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      protocol_err_o <= 1'b0;
    end else begin
      protocol_err_o <= (state == srs_pkg::ST_ERROR);
    end
  end

endmodule

// [bench/srs_monitor.sv]
/* port checker for the self refresh sequencer.
   assumes a bind onto srs_self_refresh. */
`timescale 1ns/10ps
module srs_monitor #(
  parameter int EXIT_CYCLES = srs_pkg::EXIT_CYC,
  parameter int TICK_CYCLES = srs_pkg::SELF_TICK_CYC
) (
  input wire logic                      core_clk_i,
  input wire logic                      rst_i,
  input wire srs_pkg::srs_pins_t        pins_i,
  input wire logic                      self_refresh_o,
  input wire logic                      cmd_ready_o,
  input wire logic                      refresh_busy_o,
  input wire logic                      protocol_err_o,
  input wire logic [srs_pkg::ROW_W-1:0] refresh_row_o
);
  localparam int TICK_WIN = TICK_CYCLES + 4;
  wire logic idle = cmd_ready_o && !self_refresh_o && !protocol_err_o;
  wire logic bad = !pins_i.cmd[3] && (pins_i.cmd != srs_pkg::CMD_NOP);
  wire logic rfsh = pins_i.cmd == srs_pkg::CMD_REFRESH;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence exit_start; $rose(pins_i.cke) && self_refresh_o; endsequence
  sequence exit_wait; !cmd_ready_o[*2] ##[1:2] cmd_ready_o; endsequence
  enter_self_a: assert property (idle && !pins_i.cke && rfsh |=> ##1 self_refresh_o)
    else $error("self refresh not entered");
  auto_count_a: assert property (
    idle && pins_i.cke && rfsh |=> refresh_row_o == $past(refresh_row_o) + 1'b1)
    else $error("auto refresh not counted");
  self_hold_a: assert property (self_refresh_o && !pins_i.cke |=> self_refresh_o)
    else $error("self refresh left without cke");
  self_tick_a: assert property ($rose(self_refresh_o) |-> ##[1:TICK_WIN] refresh_busy_o)
    else $error("no internal refresh");
  exit_delay_a: assert property (exit_start ##1 !bad |-> exit_wait)
    else $error("exit delay wrong");
  exit_error_a: assert property (exit_start ##1 bad |-> ##[1:2] protocol_err_o)
    else $error("command in exit delay not flagged");
  row_step_a: assert property (
    refresh_row_o != $past(refresh_row_o) |-> refresh_row_o == $past(refresh_row_o) + 1'b1)
    else $error("row counter jumped");
  sequence busy_tail; refresh_busy_o[*2]; endsequence
  busy_hold_a: assert property ($rose(refresh_busy_o) |=> busy_tail)
    else $error("refresh cut short");
  self_block_a: assert property (self_refresh_o |-> !cmd_ready_o)
    else $error("commands accepted in self refresh");
endmodule
bind srs_self_refresh srs_monitor #(.EXIT_CYCLES(EXIT_CYCLES), .TICK_CYCLES(TICK_CYCLES))
  srs_monitor_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .pins_i(pins_i),
  .self_refresh_o(self_refresh_o), .cmd_ready_o(cmd_ready_o), .refresh_busy_o(refresh_busy_o),
  .protocol_err_o(protocol_err_o), .refresh_row_o(refresh_row_o));

// [bench/srs_ctrl_model.sv]
/* controller model driving the command and clock-enable pins.
   assumes a free-running core clock; the bench calls its tasks. */
`timescale 1ns/10ps
module srs_ctrl_model (
  input  wire logic          core_clk_i,
  output srs_pkg::srs_pins_t pins_o
);
  initial pins_o = '{cke: 1'b1, cmd: srs_pkg::CMD_NOP};
  task automatic step(input logic cke, input logic [3:0] cmd);
    @(posedge core_clk_i);
    #1 pins_o = '{cke: cke, cmd: cmd};
  endtask
  task automatic auto; // banks idle, no burst
    step(1'b1, srs_pkg::CMD_REFRESH);
    step(1'b1, srs_pkg::CMD_NOP);
  endtask
  task automatic enter(input int stay); // stay well over minimum
    step(1'b0, srs_pkg::CMD_REFRESH);
    for (int i = 0; i < stay; i++) step(1'b0, 4'(i)); // cke low, junk cmd
  endtask
  task automatic leave(input logic [3:0] cmd); // clock never stops
    step(1'b1, srs_pkg::CMD_NOP);
    step(1'b1, cmd); // nop unless told otherwise
    step(1'b1, srs_pkg::CMD_NOP); // no activate follows
  endtask
endmodule

// [bench/sdram_self_refresh_sequencing_test.sv]
/* testbench for srs_self_refresh.
   assumes srs_ctrl_model drives every pin. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp=%h got=%h", n, e, g); end end
module sdram_self_refresh_sequencing_test;
  logic                      core_clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  srs_pkg::srs_pins_t        pins;
  logic                      self_r, ready, busy, perr;
  logic [srs_pkg::ROW_W-1:0] row, r0;
  int                        err_total = 0;
  int                        checked = 0;
  initial forever #20 core_clk_i = ~core_clk_i;
  srs_ctrl_model srs_ctrl_model_inst (.core_clk_i(core_clk_i), .pins_o(pins));
  srs_self_refresh #(.TICK_CYCLES(8)) srs_self_refresh_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .pins_i(pins), .self_refresh_o(self_r), .cmd_ready_o(ready),
    .refresh_busy_o(busy), .protocol_err_o(perr), .refresh_row_o(row));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(posedge core_clk_i) #1;
      n++;
    end
    `CHK("ready", 1'b1, ready)
    if (n == 40) report_and_stop();
  endtask
  task automatic t_self;
    r0 = row;
    srs_ctrl_model_inst.enter(30);
    `CHK("in self", 1'b1, self_r)
    `CHK("ignoring", 1'b0, ready)
    `CHK("ticks", 1'b1, row != r0)
    srs_ctrl_model_inst.leave(srs_pkg::CMD_NOP);
    wait_ready();
    r0 = row;
    srs_ctrl_model_inst.auto();
    `CHK("shared row", r0 + 1'b1, row)
  endtask
  task automatic t_err;
    srs_ctrl_model_inst.enter(12);
    srs_ctrl_model_inst.leave(4'h3);
    @(posedge core_clk_i) #1;
    `CHK("exit err", 1'b1, perr)
    wait_ready();
    `CHK("err clear", 1'b0, perr)
  endtask
  initial begin
    repeat (8) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    `CHK("row rst", 13'h0, row)
    `CHK("ready rst", 1'b1, ready)
    r0 = row;
    srs_ctrl_model_inst.auto();
    `CHK("auto row", r0 + 1'b1, row)
    `CHK("auto busy", 1'b1, busy)
    t_self();
    t_err();
    report_and_stop();
  end
endmodule
